/* File: pkg/fpu_pkg.sv */
// constants, opcodes and field layouts shared by the float op block
`default_nettype none
package fpu_pkg;
  localparam logic [7:0]  OP_READ_REG_FLOAT          = 8'h1a;
  localparam logic [7:0]  OP_READ_WORKING_FLOAT      = 8'h1b;
  localparam logic [7:0]  OP_READ_INDEXED_FLOAT      = 8'h1c;
  localparam logic [7:0]  OP_READ_ZERO_FLOAT         = 8'h1d;
  localparam logic [7:0]  OP_COPY_TO_WORKING         = 8'h20;
  localparam logic [7:0]  OP_COPY_ZERO_TO_WORKING    = 8'h29;
  localparam logic [7:0]  OP_FLOAT_SUBTRACT_ZERO     = 8'h2b;
  localparam logic [7:0]  OP_LOAD_WORKING_IMMEDIATE  = 8'h32;
  localparam logic [7:0]  OP_FLOAT_SUBTRACT_IMMEDIATE = 8'h34;
  localparam logic [7:0]  OP_FLOAT_STATUS_OF_REG     = 8'h3b;
  localparam logic [7:0]  OP_FLOAT_STATUS_OF_WORKING = 8'h3c;
  localparam logic [7:0]  OP_SPLIT_INT_FRAC          = 8'h64;
  localparam logic [7:0]  OP_HOST_STATUS_FETCH       = 8'hf0;
  localparam logic [7:0]  OP_SELECT_WORKING          = 8'hf1;
  localparam logic [7:0]  OP_SELECT_INDEX            = 8'hf2;

  localparam int          REG_COUNT       = 256;
  localparam int          REG_WORD_W      = 64;
  localparam int          REG_ADDR_W      = 8;
  localparam int          WIDE_BIT        = 7;
  localparam logic [7:0]  REG_NARROW_ZERO = 8'h00;
  localparam logic [7:0]  REG_WIDE_ZERO   = 8'h80;
  localparam logic [7:0]  WORK_RESET_IDX  = 8'h00;
  localparam logic [7:0]  INDEX_RESET_IDX = 8'h00;

  localparam int          STAT_INF_BIT  = 3;
  localparam int          STAT_NAN_BIT  = 2;
  localparam int          STAT_SIGN_BIT = 1;
  localparam int          STAT_ZERO_BIT = 0;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;

  localparam logic [2:0]  RESULT_BYTES  = 3'h4;
  localparam logic [2:0]  STATUS_BYTES  = 3'h1;
  localparam logic [2:0]  LINK_LAST_BIT = 3'h7;

  localparam int          BIAS64    = 1023;
  localparam int          BIAS32    = 127;
  localparam int          FRAC64    = 52;
  localparam int          FRAC32    = 23;
  localparam logic [10:0] EXP64_ALL = 11'h7ff;
  localparam logic [7:0]  EXP32_ALL = 8'hff;
  localparam logic [63:0] QNAN64    = 64'h7ff8000000000000;
  localparam logic [31:0] QNAN32    = 32'h7fc00000;
endpackage
`default_nettype wire

/* File: verilog/fpu_regfile.sv */
// general register array, 256 words of 64 bits, registered read
`timescale 1ns/1ps
`default_nettype none
module fpu_regfile
  import fpu_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [REG_ADDR_W-1:0] rd_addr,
  output logic      [REG_WORD_W-1:0] rd_data_q,
  input  wire logic                  wr_en,
  input  wire logic [REG_ADDR_W-1:0] wr_addr,
  input  wire logic [REG_WORD_W-1:0] wr_data
);
  logic [REG_WORD_W-1:0] mem_q [REG_COUNT];

  // cleared so that a read before any write is defined
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule
`default_nettype wire

/* File: verilog/fpu_link.sv */
// serial byte link, runs on the host's link clock
`timescale 1ns/1ps
`default_nettype none
module fpu_link
  import fpu_pkg::*;
(
  input  wire logic       link_clock,
  input  wire logic       rst,
  input  wire logic       link_cs_n,
  input  wire logic       link_mosi,
  input  wire logic [7:0] tx_byte,
  output logic            link_miso,
  output logic      [7:0] rx_byte_q,
  output logic            rx_toggle_q
);
  logic       frame_rst;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;

  // deselect realigns to a byte boundary; clock is idle then
  assign frame_rst = rst | link_cs_n;

  always_ff @(posedge link_clock or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
      link_miso <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], link_mosi};
      // tx_byte is quasi-static: core only moves it in the byte gap
      link_miso <= tx_byte[LINK_LAST_BIT - bit_cnt_q];
    end
  end

  // toggle survives deselect so no false byte event is made
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      rx_byte_q   <= '0;
      rx_toggle_q <= 1'b0;
    end else if (!link_cs_n && bit_cnt_q == LINK_LAST_BIT) begin
      rx_byte_q   <= {shift_q, link_mosi};
      rx_toggle_q <= ~rx_toggle_q;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/fp_read_set_status_sub_ops.sv */
// float read, set, split, status and subtract instruction executor
`timescale 1ns/1ps
`default_nettype none
module fp_read_set_status_sub_ops
  import fpu_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       link_clock,
  input  wire logic       link_cs_n,
  input  wire logic       link_mosi,
  input  wire logic       alt_float_format_mode,
  output logic            link_miso,
  output logic            busy_q,
  output logic      [7:0] float_status_byte
);
  typedef enum logic [2:0] {
    st_idle,
    st_operand,
    st_fetch_src,
    st_fetch_work,
    st_exec,
    st_frac
  } state_t;

  state_t           state_q;
  logic [7:0]       op_q;
  logic [7:0]       operand_q;
  logic [7:0]       src_idx_q;
  logic [7:0]       a_idx_q;
  logic [7:0]       x_idx_q;
  logic [63:0]      src_raw_q;
  logic [63:0]      frac_q;
  logic [31:0]      tx_word_q;
  logic [2:0]       tx_left_q;
  logic [2:0]       rx_sync_q;
  logic [1:0]       mode_sync_q;
  logic [7:0]       rx_byte;
  logic             rx_toggle;
  logic             byte_evt;
  logic             cmd_evt;
  logic [63:0]      rd_data;
  logic [7:0]       rd_addr;
  logic             wr_en;
  logic [7:0]       wr_addr;
  logic [63:0]      wr_data;
  logic [63:0]      a64;
  logic [63:0]      s64;
  logic [63:0]      nar;
  logic [31:0]      rd32;
  logic [63:0]      imm64;
  logic [127:0]     parts;
  logic [63:0]      result;
  logic             writes;

  function automatic logic is_nan64(input logic [63:0] v);
    return (v[62:52] == EXP64_ALL) && (v[51:0] != '0);
  endfunction

  function automatic logic is_inf64(input logic [63:0] v);
    return (v[62:52] == EXP64_ALL) && (v[51:0] == '0);
  endfunction

  function automatic logic [63:0] neg64(input logic [63:0] v);
    return {~v[63], v[62:0]};
  endfunction

  // single denormals are normalised; widening is always exact
  function automatic logic [63:0] f32_to_f64(input logic [31:0] v);
    logic [23:0] mm;
    logic [10:0] ee;
    mm = {1'b0, v[22:0]};
    ee = 11'(BIAS64 - BIAS32 + 1);
    if (v[30:23] == EXP32_ALL) begin
      return {v[31], EXP64_ALL, v[22:0], 29'h0};
    end
    if (v[30:23] != 8'h00) begin
      return {v[31], 11'(v[30:23]) + 11'(BIAS64 - BIAS32), v[22:0], 29'h0};
    end
    if (v[22:0] == '0) begin
      return {v[31], 63'h0};
    end
    for (int i = 0; i < FRAC32; i++) begin
      if (!mm[FRAC32]) begin
        mm = mm << 1;
        ee = ee - 11'h1;
      end
    end
    return {v[31], ee, mm[22:0], 29'h0};
  endfunction

  // narrowing truncates; results below single range flush to zero
  function automatic logic [31:0] f64_to_f32(input logic [63:0] v);
    int ee;
    ee = int'(v[62:52]) - (BIAS64 - BIAS32);
    if (is_nan64(v)) begin
      return {v[63], QNAN32[30:0]};
    end
    if (is_inf64(v) || ee >= int'(EXP32_ALL)) begin
      return {v[63], EXP32_ALL, 23'h0};
    end
    if (ee <= 0) begin
      return {v[63], 31'h0};
    end
    return {v[63], ee[7:0], v[51:29]};
  endfunction

  // move a raw word into the precision of the destination register
  function automatic logic [63:0] fit(input logic [7:0]  dst,
                                      input logic [7:0]  src,
                                      input logic [63:0] raw);
    if (dst[WIDE_BIT] == src[WIDE_BIT]) begin
      return dst[WIDE_BIT] ? raw : {32'h0, raw[31:0]};
    end
    if (dst[WIDE_BIT]) begin
      return f32_to_f64(raw[31:0]);
    end
    return {32'h0, f64_to_f32(raw)};
  endfunction

  function automatic logic [63:0] int8_to_f64(input logic [7:0] b);
    logic [7:0]  mag;
    logic [52:0] mm;
    int          p;
    mag = b[7] ? 8'(~b + 8'h1) : b;
    p = 0;
    for (int i = 0; i < 8; i++) begin
      if (mag[i]) begin
        p = i;
      end
    end
    mm = 53'(mag) << (FRAC64 - p);
    if (b == 8'h00) begin
      return '0;
    end
    return {b[7], 11'(BIAS64 + p), mm[51:0]};
  endfunction

  // double add with truncation; three guard bits kept for the align
  function automatic logic [63:0] add64(input logic [63:0] a,
                                        input logic [63:0] b);
    logic [63:0] x;
    logic [63:0] y;
    logic [10:0] ex;
    logic [10:0] ey;
    logic [10:0] er;
    logic [55:0] mx;
    logic [55:0] my;
    logic [56:0] ms;
    logic [10:0] d;
    x  = a;
    y  = b;
    if (a[62:0] < b[62:0]) begin
      x = b;
      y = a;
    end
    ex = (x[62:52] == '0) ? 11'h1 : x[62:52];
    ey = (y[62:52] == '0) ? 11'h1 : y[62:52];
    mx = {x[62:52] != '0, x[51:0], 3'h0};
    my = {y[62:52] != '0, y[51:0], 3'h0};
    d  = ex - ey;
    er = ex;
    if (is_nan64(a) || is_nan64(b)) begin
      return QNAN64;
    end
    if (is_inf64(a) && is_inf64(b) && a[63] != b[63]) begin
      return QNAN64;
    end
    if (is_inf64(a)) begin
      return a;
    end
    if (is_inf64(b)) begin
      return b;
    end
    my = (d > 11'd55) ? '0 : my >> d;
    ms = (x[63] == y[63]) ? {1'b0, mx} + {1'b0, my} : {1'b0, mx} - {1'b0, my};
    if (ms[56]) begin
      ms = ms >> 1;
      er = er + 11'h1;
    end else begin
      for (int i = 0; i < 55; i++) begin
        if (!ms[55] && er > 11'h1) begin
          ms = ms << 1;
          er = er - 11'h1;
        end
      end
    end
    if (ms == '0) begin
      return '0;
    end
    if (er == EXP64_ALL) begin
      return {x[63], EXP64_ALL, 52'h0};
    end
    if (!ms[55]) begin
      er = '0;
    end
    return {x[63], er, ms[54:3]};
  endfunction

  // upper half integer part, lower half fraction with original sign
  function automatic logic [127:0] split64(input logic [63:0] v);
    logic [63:0] mask;
    logic [63:0] ip;
    logic [63:0] diff;
    int          unb;
    unb = int'(v[62:52]) - BIAS64;
    if (is_nan64(v) || is_inf64(v)) begin
      return {64'h0, QNAN64};
    end
    if (unb < 0) begin
      return {v[63], 63'h0, v};
    end
    if (unb >= FRAC64) begin
      return {v, v[63], 63'h0};
    end
    mask = ~((64'h1 << (FRAC64 - unb)) - 64'h1);
    ip   = v & mask;
    diff = add64(v, neg64(ip));
    return {ip, v[63], diff[62:0]};
  endfunction

  function automatic logic [7:0] fstat(input logic [63:0] v);
    logic [7:0] s;
    s = STATUS_RESET;
    s[STAT_INF_BIT]  = is_inf64(v);
    s[STAT_NAN_BIT]  = is_nan64(v);
    s[STAT_SIGN_BIT] = v[63] && !is_nan64(v);
    s[STAT_ZERO_BIT] = (v[62:0] == '0);
    return s;
  endfunction

  function automatic logic needs_operand(input logic [7:0] op);
    return op == OP_READ_REG_FLOAT || op == OP_COPY_TO_WORKING ||
           op == OP_LOAD_WORKING_IMMEDIATE || op == OP_FLOAT_STATUS_OF_REG ||
           op == OP_FLOAT_SUBTRACT_IMMEDIATE || op == OP_SELECT_WORKING ||
           op == OP_SELECT_INDEX;
  endfunction

  function automatic logic is_read(input logic [7:0] op);
    return op == OP_READ_REG_FLOAT || op == OP_READ_WORKING_FLOAT ||
           op == OP_READ_INDEXED_FLOAT || op == OP_READ_ZERO_FLOAT;
  endfunction

  function automatic logic runs_alone(input logic [7:0] op);
    return op == OP_READ_WORKING_FLOAT || op == OP_READ_INDEXED_FLOAT ||
           op == OP_READ_ZERO_FLOAT || op == OP_COPY_ZERO_TO_WORKING ||
           op == OP_FLOAT_SUBTRACT_ZERO || op == OP_SPLIT_INT_FRAC ||
           op == OP_FLOAT_STATUS_OF_WORKING;
  endfunction

  function automatic logic [7:0] src_index(input logic [7:0] op,
                                           input logic [7:0] opnd,
                                           input logic [7:0] a_idx,
                                           input logic [7:0] x_idx);
    logic [7:0] zero_idx;
    zero_idx = a_idx[WIDE_BIT] ? REG_WIDE_ZERO : REG_NARROW_ZERO;
    case (op)
      OP_READ_REG_FLOAT, OP_COPY_TO_WORKING,
      OP_FLOAT_STATUS_OF_REG:                  return opnd;
      OP_READ_INDEXED_FLOAT:                   return x_idx;
      OP_READ_ZERO_FLOAT, OP_COPY_ZERO_TO_WORKING, OP_FLOAT_SUBTRACT_ZERO,
      OP_SPLIT_INT_FRAC:                       return zero_idx;
      default:                                 return a_idx;
    endcase
  endfunction

  fpu_link u_link (
    .link_clock  (link_clock),
    .rst         (rst),
    .link_cs_n   (link_cs_n),
    .link_mosi   (link_mosi),
    .tx_byte     (tx_word_q[31:24]),
    .link_miso   (link_miso),
    .rx_byte_q   (rx_byte),
    .rx_toggle_q (rx_toggle)
  );

  fpu_regfile u_regs (
    .clock     (clock),
    .rst       (rst),
    .rd_addr   (rd_addr),
    .rd_data_q (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // byte event toggle and mode pin both cross into the core clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_sync_q   <= '0;
      mode_sync_q <= '0;
    end else begin
      rx_sync_q   <= {rx_sync_q[1:0], rx_toggle};
      mode_sync_q <= {mode_sync_q[0], alt_float_format_mode};
    end
  end

  assign byte_evt = rx_sync_q[1] ^ rx_sync_q[2];
  // bytes clocked in while a result drains are dummies, not commands
  assign cmd_evt  = byte_evt && tx_left_q == '0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= st_idle;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (cmd_evt && needs_operand(rx_byte)) begin
            state_q <= st_operand;
          end else if (cmd_evt && runs_alone(rx_byte)) begin
            state_q <= st_fetch_src;
          end
        end
        st_operand: begin
          if (byte_evt) begin
            state_q <= (op_q == OP_SELECT_WORKING || op_q == OP_SELECT_INDEX)
                       ? st_idle : st_fetch_src;
          end
        end
        st_fetch_src:  state_q <= st_fetch_work;
        st_fetch_work: state_q <= st_exec;
        st_exec: begin
          state_q <= (op_q == OP_SPLIT_INT_FRAC) ? st_frac : st_idle;
        end
        st_frac:       state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      op_q      <= '0;
      operand_q <= '0;
      src_idx_q <= '0;
    end else if (state_q == st_idle && cmd_evt) begin
      op_q      <= rx_byte;
      src_idx_q <= src_index(rx_byte, operand_q, a_idx_q, x_idx_q);
    end else if (state_q == st_operand && byte_evt) begin
      operand_q <= rx_byte;
      src_idx_q <= src_index(op_q, rx_byte, a_idx_q, x_idx_q);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      src_raw_q <= '0;
    end else if (state_q == st_fetch_work) begin
      src_raw_q <= rd_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      a_idx_q <= WORK_RESET_IDX;
      x_idx_q <= INDEX_RESET_IDX;
    end else if (state_q == st_operand && byte_evt) begin
      if (op_q == OP_SELECT_WORKING) begin
        a_idx_q <= rx_byte;
      end
      if (op_q == OP_SELECT_INDEX) begin
        x_idx_q <= rx_byte;
      end
    end else if (state_q == st_exec && op_q == OP_READ_INDEXED_FLOAT) begin
      x_idx_q <= x_idx_q + 8'h1;
    end
  end

  always_comb begin
    a64    = fit(REG_WIDE_ZERO, a_idx_q, rd_data);
    s64    = fit(REG_WIDE_ZERO, src_idx_q, src_raw_q);
    nar    = fit(REG_NARROW_ZERO, src_idx_q, src_raw_q);
    rd32   = nar[31:0];
    if (mode_sync_q[1]) begin
      rd32 = {nar[30:23], nar[31], nar[22:0]};
    end
    imm64  = int8_to_f64(operand_q);
    parts  = split64(a64);
    writes = 1'b1;
    case (op_q)
      OP_COPY_TO_WORKING, OP_COPY_ZERO_TO_WORKING:
        result = fit(a_idx_q, src_idx_q, src_raw_q);
      OP_LOAD_WORKING_IMMEDIATE:
        result = fit(a_idx_q, REG_WIDE_ZERO, imm64);
      OP_FLOAT_SUBTRACT_IMMEDIATE:
        // specials fall out of add64: nan stays, infinity is kept
        result = fit(a_idx_q, REG_WIDE_ZERO,
                     add64(a64, neg64(imm64)));
      OP_FLOAT_SUBTRACT_ZERO:
        result = fit(a_idx_q, REG_WIDE_ZERO,
                     add64(a64, neg64(s64)));
      OP_SPLIT_INT_FRAC:
        result = fit(a_idx_q, REG_WIDE_ZERO, parts[127:64]);
      default: begin
        result = rd_data;
        writes = 1'b0;
      end
    endcase
    // width of each operand follows its register number
    wr_en   = (state_q == st_exec && writes) || state_q == st_frac;
    wr_addr = (state_q == st_frac) ? src_idx_q : a_idx_q;
    wr_data = (state_q == st_frac) ? frac_q : result;
    rd_addr = (state_q == st_fetch_src) ? src_idx_q : a_idx_q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frac_q <= '0;
    end else if (state_q == st_exec && op_q == OP_SPLIT_INT_FRAC) begin
      frac_q <= fit(src_idx_q, REG_WIDE_ZERO, parts[63:0]);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      float_status_byte <= STATUS_RESET;
    end else if (state_q == st_exec && (op_q == OP_FLOAT_STATUS_OF_REG ||
                 op_q == OP_FLOAT_STATUS_OF_WORKING)) begin
      float_status_byte <= fstat(s64);
    end
  end

  // result bytes leave MSB first, one per link byte the host clocks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_word_q <= '0;
      tx_left_q <= '0;
    end else if (state_q == st_exec && is_read(op_q)) begin
      tx_word_q <= rd32;
      tx_left_q <= RESULT_BYTES;
    end else if (state_q == st_idle && cmd_evt &&
                 rx_byte == OP_HOST_STATUS_FETCH) begin
      tx_word_q <= {float_status_byte, 24'h0};
      tx_left_q <= STATUS_BYTES;
    end else if (byte_evt && tx_left_q != '0) begin
      tx_word_q <= {tx_word_q[23:0], 8'h00};
      tx_left_q <= tx_left_q - 3'h1;
    end
  end

  // lags the state by one cycle; the byte gap on the link covers it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != st_idle);
    end
  end
endmodule
`default_nettype wire

/* File: verification/fp_ops_sva.sv */
// port-level assertions for the float op block
`timescale 1ns/1ps
`default_nettype none
module fp_ops_sva (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       link_cs_n,
  input wire logic       link_miso,
  input wire logic       busy_q,
  input wire logic [7:0] float_status_byte
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic [7:0] s = float_status_byte;
  sequence exec_start_s;
    !busy_q ##1 busy_q;
  endsequence
  status_hi_zero_a: assert property (s[7:4] == 4'h0)
    else $error("status upper bits set");
  inf_nan_excl_a: assert property (!(s[3] && s[2]))
    else $error("status infinity and nan together");
  nan_unsigned_a: assert property (s[2] |-> !s[1])
    else $error("status nan with sign");
  zero_finite_a: assert property (s[0] |-> !s[3] && !s[2])
    else $error("status zero with infinity or nan");
  reset_values_a: assert property ($past(rst) |-> s == 8'h00 && !busy_q)
    else $error("values after reset wrong");
  exec_ends_a: assert property (exec_start_s |-> ##[1:60] !busy_q)
    else $error("busy held too long");
  // status may only move around an executing instruction
  status_quiet_a: assert property ($changed(s) |->
    (busy_q || $past(busy_q) || $past(busy_q, 2)) or (##[1:2] busy_q))
    else $error("status changed while idle");
  miso_idle_a: assert property (link_cs_n [*2] |-> !link_miso)
    else $error("miso driven outside a frame");
endmodule
bind fp_read_set_status_sub_ops fp_ops_sva i_sva (
  .clock(clock), .rst(rst), .link_cs_n(link_cs_n), .link_miso(link_miso),
  .busy_q(busy_q), .float_status_byte(float_status_byte));
`default_nettype wire

/* File: verification/host_link_model.sv */
// host side of the serial link: frames bytes, gathers results
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  output logic      link_clock,
  output logic      link_cs_n,
  output logic      link_mosi,
  input  wire logic link_miso
);
  initial begin
    link_clock = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b1;
  end
  // clock stands still outside frames; gap keeps core ahead of us
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    link_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      link_mosi = tx[i];
      #3 link_clock = 1'b1;
      #3 link_clock = 1'b0;
      rx[i] = link_miso;
    end
    #3 link_cs_n = 1'b1;
    link_mosi = ~link_mosi;
    #150;
  endtask
  task automatic read_word(output logic [31:0] w);
    for (int k = 3; k >= 0; k--) begin
      xfer(8'h00, w[k*8 +: 8]);
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the float op block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fpu_pkg::*;
  logic            clock;
  logic            rst;
  logic            alt_float_format_mode;
  wire logic       link_clock;
  wire logic       link_cs_n;
  wire logic       link_mosi;
  wire logic       link_miso;
  wire logic       busy_q;
  wire logic [7:0] float_status_byte;
  logic      [7:0] dummy;
  int              failures;
  int              n_compared;
  fp_read_set_status_sub_ops i_dut (
    .clock(clock), .rst(rst), .link_clock(link_clock),
    .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .alt_float_format_mode(alt_float_format_mode), .link_miso(link_miso),
    .busy_q(busy_q), .float_status_byte(float_status_byte));
  host_link_model i_host (
    .link_clock(link_clock), .link_cs_n(link_cs_n),
    .link_mosi(link_mosi), .link_miso(link_miso));
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bytes sent while busy are lost, except an awaited operand, so op waits for idle after its byte
  task automatic op(input logic [7:0] b);
    int n;
    n = 0;
    i_host.xfer(b, dummy);
    // sampled on the falling edge, clear of the edge that launches busy
    repeat (10) @(negedge clock);
    while (busy_q !== 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (busy_q !== 1'b0) begin
      failures++;
      $display("Error busy expected 0 seen %b", busy_q);
      end_sim();
    end
  endtask
  // busy stays up while an operand is awaited, so send it straight on
  task automatic op2(input logic [7:0] c, input logic [7:0] v);
    i_host.xfer(c, dummy);
    op(v);
  endtask
  task automatic rd(input string what, input logic [7:0] b,
                    input logic [31:0] exp);
    logic [31:0] w;
    op(b);
    i_host.read_word(w);
    check(what, exp, w);
    $display("test %s done", what);
  endtask
  task automatic st(input logic [7:0] exp);
    logic [7:0] b;
    op(OP_HOST_STATUS_FETCH);
    i_host.xfer(8'h00, b);
    check("status", {24'h0, exp}, {24'h0, b});
    check("status port", {24'h0, exp}, {24'h0, float_status_byte});
    $display("test status done");
  endtask
  initial begin
    rst = 1'b1;
    alt_float_format_mode = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check("status reset", 32'h0, {24'h0, float_status_byte});
    op2(OP_LOAD_WORKING_IMMEDIATE, 8'h05);
    rd("imm 5", OP_READ_WORKING_FLOAT, 32'h40a00000);
    op2(OP_LOAD_WORKING_IMMEDIATE, 8'h80);
    rd("imm -128", OP_READ_WORKING_FLOAT, 32'hc3000000);
    op2(OP_SELECT_WORKING, 8'h01);
    op2(OP_LOAD_WORKING_IMMEDIATE, 8'h03);
    op2(OP_FLOAT_SUBTRACT_IMMEDIATE, 8'h7f);
    rd("sub imm", OP_READ_WORKING_FLOAT, 32'hc2f80000);
    op(OP_COPY_ZERO_TO_WORKING);
    rd("copy zero", OP_READ_WORKING_FLOAT, 32'hc3000000);
    rd("read zero", OP_READ_ZERO_FLOAT, 32'hc3000000);
    op(OP_FLOAT_SUBTRACT_ZERO);
    op(OP_FLOAT_STATUS_OF_WORKING);
    st(8'h01);
    op2(OP_LOAD_WORKING_IMMEDIATE, 8'h07);
    op(OP_SPLIT_INT_FRAC);
    rd("split int", OP_READ_WORKING_FLOAT, 32'h40e00000);
    rd("split frac", OP_READ_ZERO_FLOAT, 32'h00000000);
    op2(OP_SELECT_WORKING, 8'h80);
    op2(OP_LOAD_WORKING_IMMEDIATE, 8'hff);
    rd("wide work", OP_READ_WORKING_FLOAT, 32'hbf800000);
    rd("wide zero", OP_READ_ZERO_FLOAT, 32'hbf800000);
    op(OP_FLOAT_STATUS_OF_WORKING);
    st(8'h02);
    op2(OP_COPY_TO_WORKING, 8'h01);
    i_host.xfer(OP_READ_REG_FLOAT, dummy);
    rd("copy widen", 8'h80, 32'h40e00000);
    op2(OP_FLOAT_STATUS_OF_REG, 8'h00);
    st(8'h01);
    op2(OP_SELECT_INDEX, 8'h01);
    rd("index 1", OP_READ_INDEXED_FLOAT, 32'h40e00000);
    rd("index 2", OP_READ_INDEXED_FLOAT, 32'h00000000);
    @(posedge clock) alt_float_format_mode <= 1'b1;
    repeat (4) @(posedge clock);
    i_host.xfer(OP_READ_REG_FLOAT, dummy);
    rd("alt format", 8'h01, 32'h81600000);
    end_sim();
  end
endmodule
`default_nettype wire
